// ===== fcc_defines.vh
`ifndef FCC_DEFINES_VH
`define FCC_DEFINES_VH
// opcodes
`define FCC_OP_RESET_ARM 8'h66
`define FCC_OP_RESET 8'h99
`define FCC_OP_QUAD_ENTER 8'h38
`define FCC_OP_QUAD_EXIT 8'hFF
`define FCC_OP_WL_SET 8'h06
`define FCC_OP_WL_CLEAR 8'h04
`define FCC_OP_VOL_WEN 8'h50
`define FCC_OP_STATUS_READ 8'h05
`define FCC_OP_STATUS_WRITE 8'h01
`define FCC_OP_PROG 8'h02
`define FCC_OP_PROG4 8'h12
`define FCC_OP_QPROG 8'h32
`define FCC_OP_QPROG4 8'h34
`define FCC_OP_SECT 8'h20
`define FCC_OP_SECT4 8'h21
`define FCC_OP_HALF 8'h52
`define FCC_OP_HALF4 8'h5C
`define FCC_OP_BLK 8'hD8
`define FCC_OP_BLK4 8'hDC
`define FCC_OP_CE1 8'hC7
`define FCC_OP_CE2 8'h60
`define FCC_OP_READ 8'h03
`define FCC_OP_READ4 8'h13
`define FCC_OP_DOR 8'h3B
`define FCC_OP_DOR4 8'h3C
`define FCC_OP_DIO 8'hBB
`define FCC_OP_DIO4 8'hBC
`define FCC_OP_QOR 8'h6B
`define FCC_OP_QOR4 8'h6C
// status fields
`define FCC_SR_BUSY 0
`define FCC_SR_LATCH 1
`define FCC_SR_RST 8'h00
// timing
`define FCC_CLK_NS 40
`define FCC_RECOV_ERASE_NS 28000
`define FCC_RECOV_OTHER_NS 1000
`define FCC_VOL_LOAD_NS 50
`endif

// ===== fcc_shift.v
`timescale 1ns/100ps
// ----------------------------------------
// opcode shifter
// ----------------------------------------
module fcc_shift
(
    input wire clk_i,
    input wire rst_i,
    input wire frame_start_i,
    input wire sclk_rise_i,
    input wire quad_i,
    input wire [3:0] dq_i,
    output reg [7:0] byte_o,
    output reg byte_done_o
);
    reg [3:0] cnt_reg;
    reg [7:0] sh_reg;
    always @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            cnt_reg <= 4'h0;
            sh_reg <= 8'h00;
            byte_o <= 8'h00;
            byte_done_o <= 1'b0;
        end
        else
        begin
            byte_done_o <= 1'b0;
            if (frame_start_i)
            begin
                cnt_reg <= 4'h0;
            end
            else if (sclk_rise_i && cnt_reg < 4'h8)
            begin
                if (quad_i)
                begin
                    sh_reg <= {sh_reg[3:0], dq_i};
                    cnt_reg <= cnt_reg + 4'h4;
                    if (cnt_reg == 4'h4)
                    begin
                        byte_o <= {sh_reg[3:0], dq_i};
                        byte_done_o <= 1'b1;
                    end
                end
                else
                begin
                    sh_reg <= {sh_reg[6:0], dq_i[0]};
                    cnt_reg <= cnt_reg + 4'h1;
                    if (cnt_reg == 4'h7)
                    begin
                        byte_o <= {sh_reg[6:0], dq_i[0]};
                        byte_done_o <= 1'b1;
                    end
                end
            end
        end
    end
endmodule // fcc_shift

// ===== fcc_ctrl.v
`timescale 1ns/100ps
`include "fcc_defines.vh"
module fcc_ctrl
#(
    parameter RECOV_ERASE_CYC = (`FCC_RECOV_ERASE_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS,
    parameter RECOV_OTHER_CYC = (`FCC_RECOV_OTHER_NS + `FCC_CLK_NS - 1) / `FCC_CLK_NS
)
(
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire CS_N_I,
    input wire SCLK_I,
    input wire [3:0] DQ_I,
    input wire [7:0] NV_STATUS_I,
    input wire OP_BUSY_I,
    input wire OP_IS_ERASE_I,
    input wire OP_DONE_I,
    input wire DEEP_PD_I,
    input wire ENH_READ_I,
    input wire [7:0] STATUS_WR_DATA_I,
    input wire STATUS_WR_VALID_I,
    output reg [3:0] DQ_O,
    output reg [3:0] DQ_OE_O,
    output reg QUAD_CMD_MODE_O,
    output reg ENH_READ_EXIT_O,
    output reg WRITE_ENABLE_LATCH_O,
    output reg VOL_WRITE_ARMED_O,
    output reg [7:0] VOL_STATUS_O,
    output reg VOL_STATUS_USE_O,
    output reg OP_ABORT_O,
    output reg SOFT_RESET_O,
    output reg RESET_BUSY_O,
    output reg [7:0] CMD_ACCEPT_O,
    output reg CMD_ACCEPT_STB_O,
    output reg CMD_REJECT_STB_O
);
    localparam RECOV_W = 16;
    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    reg [1:0] cs_sync_reg;
    reg [1:0] clk_sync_reg;
    reg [3:0] dq_s1_reg;
    reg [3:0] dq_s2_reg;
    reg cs_prev_reg;
    reg clk_prev_reg;
    always @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            cs_sync_reg <= 2'b11;
            clk_sync_reg <= 2'b00;
            dq_s1_reg <= 4'h0;
            dq_s2_reg <= 4'h0;
            cs_prev_reg <= 1'b1;
            clk_prev_reg <= 1'b0;
        end
        else
        begin
            cs_sync_reg <= {cs_sync_reg[0], CS_N_I};
            clk_sync_reg <= {clk_sync_reg[0], SCLK_I};
            dq_s1_reg <= DQ_I;
            dq_s2_reg <= dq_s1_reg;
            cs_prev_reg <= cs_sync_reg[1];
            clk_prev_reg <= clk_sync_reg[1];
        end
    end
    wire cs_n = cs_sync_reg[1];
    wire frame_start = cs_prev_reg & ~cs_n;
    wire frame_end = ~cs_prev_reg & cs_n;
    wire sclk_rise = ~cs_n & clk_sync_reg[1] & ~clk_prev_reg;
    wire sclk_fall = ~cs_n & ~clk_sync_reg[1] & clk_prev_reg;
    wire [7:0] rx_byte;
    wire rx_done;
    fcc_shift u_shift
    (
        .clk_i(SYS_CLK_I),
        .rst_i(SYS_RST_I),
        .frame_start_i(frame_start),
        .sclk_rise_i(sclk_rise),
        .quad_i(QUAD_CMD_MODE_O),
        .dq_i(dq_s2_reg),
        .byte_o(rx_byte),
        .byte_done_o(rx_done)
    );
    // ----------------------------------------
    // frame state
    // ----------------------------------------
    reg [7:0] op_reg;
    reg have_op_reg;
    reg extra_reg;
    reg reset_armed_reg;
    reg sr_read_reg;
    reg [2:0] bit_cnt_reg;
    reg [RECOV_W-1:0] recov_reg;
    reg [1:0] vol_cnt_reg;
    wire [7:0] status_now = {VOL_STATUS_O[7:2], WRITE_ENABLE_LATCH_O, OP_BUSY_I | RESET_BUSY_O};
    wire is_write_op = (op_reg == `FCC_OP_PROG) | (op_reg == `FCC_OP_PROG4) |
        (op_reg == `FCC_OP_QPROG) | (op_reg == `FCC_OP_QPROG4) | (op_reg == `FCC_OP_SECT) |
        (op_reg == `FCC_OP_SECT4) | (op_reg == `FCC_OP_HALF) | (op_reg == `FCC_OP_HALF4) |
        (op_reg == `FCC_OP_BLK) | (op_reg == `FCC_OP_BLK4) | (op_reg == `FCC_OP_CE1) |
        (op_reg == `FCC_OP_CE2) | (op_reg == `FCC_OP_STATUS_WRITE);
    wire is_quad_bad = (op_reg == `FCC_OP_READ) | (op_reg == `FCC_OP_READ4) |
        (op_reg == `FCC_OP_DOR) | (op_reg == `FCC_OP_DOR4) | (op_reg == `FCC_OP_DIO) |
        (op_reg == `FCC_OP_DIO4) | (op_reg == `FCC_OP_QOR) | (op_reg == `FCC_OP_QOR4) |
        (op_reg == `FCC_OP_QPROG) | (op_reg == `FCC_OP_QPROG4);
    // opcode-only frames other than the chip erases are dropped if clocks follow the eighth bit; a frame that holds a full opcode byte acts at chip-select rise
    wire single_frame_op = (op_reg == `FCC_OP_RESET_ARM) | (op_reg == `FCC_OP_RESET) |
        (op_reg == `FCC_OP_QUAD_ENTER) | (op_reg == `FCC_OP_QUAD_EXIT) |
        (op_reg == `FCC_OP_WL_SET) | (op_reg == `FCC_OP_WL_CLEAR) |
        (op_reg == `FCC_OP_VOL_WEN);
    wire commit = frame_end & have_op_reg;
    // ----------------------------------------
    // command execution
    // ----------------------------------------
    always @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
        begin
            op_reg <= 8'h00;
            have_op_reg <= 1'b0;
            extra_reg <= 1'b0;
            reset_armed_reg <= 1'b0;
            sr_read_reg <= 1'b0;
            bit_cnt_reg <= 3'd0;
            recov_reg <= {RECOV_W{1'b0}};
            vol_cnt_reg <= 2'd0;
            DQ_O <= 4'h0;
            DQ_OE_O <= 4'h0;
            QUAD_CMD_MODE_O <= 1'b0;
            ENH_READ_EXIT_O <= 1'b0;
            WRITE_ENABLE_LATCH_O <= 1'b0;
            VOL_WRITE_ARMED_O <= 1'b0;
            VOL_STATUS_O <= `FCC_SR_RST;
            VOL_STATUS_USE_O <= 1'b0;
            OP_ABORT_O <= 1'b0;
            SOFT_RESET_O <= 1'b0;
            RESET_BUSY_O <= 1'b0;
            CMD_ACCEPT_O <= 8'h00;
            CMD_ACCEPT_STB_O <= 1'b0;
            CMD_REJECT_STB_O <= 1'b0;
        end
        else
        begin
            ENH_READ_EXIT_O <= 1'b0;
            OP_ABORT_O <= 1'b0;
            SOFT_RESET_O <= 1'b0;
            CMD_ACCEPT_STB_O <= 1'b0;
            CMD_REJECT_STB_O <= 1'b0;
            if (recov_reg != {RECOV_W{1'b0}})
            begin
                recov_reg <= recov_reg - 1'b1;
            end
            else
            begin
                RESET_BUSY_O <= 1'b0;
            end
            if (vol_cnt_reg != 2'd0)
            begin
                vol_cnt_reg <= vol_cnt_reg - 2'd1;
            end
            if (frame_start)
            begin
                have_op_reg <= 1'b0;
                extra_reg <= 1'b0;
                sr_read_reg <= 1'b0;
            end
            if (rx_done)
            begin
                if (!have_op_reg)
                begin
                    op_reg <= rx_byte;
                    have_op_reg <= 1'b1;
                end
                else
                begin
                    extra_reg <= 1'b1;
                end
            end
            if (sclk_rise && have_op_reg)
            begin
                extra_reg <= 1'b1;
            end
            if (rx_done && !have_op_reg && rx_byte == `FCC_OP_STATUS_READ)
            begin
                sr_read_reg <= 1'b1;
                bit_cnt_reg <= 3'd7;
            end
            if (sr_read_reg && sclk_fall)
            begin
                if (QUAD_CMD_MODE_O)
                begin
                    DQ_OE_O <= 4'hF;
                    DQ_O <= bit_cnt_reg[2] ? status_now[7:4] : status_now[3:0];
                    bit_cnt_reg <= bit_cnt_reg ^ 3'd4;
                end
                else
                begin
                    DQ_OE_O <= 4'h2;
                    DQ_O <= {2'b00, status_now[bit_cnt_reg], 1'b0};
                    bit_cnt_reg <= bit_cnt_reg - 3'd1;
                end
            end
            if (cs_n)
            begin
                DQ_OE_O <= 4'h0;
            end
            if (commit && !(single_frame_op && extra_reg))
            begin
                CMD_ACCEPT_O <= op_reg;
                reset_armed_reg <= (op_reg == `FCC_OP_RESET_ARM);
                if (op_reg != `FCC_OP_VOL_WEN && op_reg != `FCC_OP_STATUS_WRITE)
                begin
                    VOL_WRITE_ARMED_O <= 1'b0;
                end
                case (op_reg)
                    `FCC_OP_RESET:
                    begin
                        if (reset_armed_reg && !DEEP_PD_I)
                        begin
                            SOFT_RESET_O <= 1'b1;
                            QUAD_CMD_MODE_O <= 1'b0;
                            WRITE_ENABLE_LATCH_O <= 1'b0;
                            VOL_STATUS_USE_O <= 1'b0;
                            VOL_STATUS_O <= NV_STATUS_I;
                            VOL_WRITE_ARMED_O <= 1'b0;
                            RESET_BUSY_O <= 1'b1;
                            OP_ABORT_O <= OP_BUSY_I;
                            recov_reg <= (OP_BUSY_I && OP_IS_ERASE_I) ?
                                RECOV_ERASE_CYC[RECOV_W-1:0] : RECOV_OTHER_CYC[RECOV_W-1:0];
                            CMD_ACCEPT_STB_O <= 1'b1;
                        end
                        else
                        begin
                            CMD_REJECT_STB_O <= 1'b1;
                        end
                    end
                    `FCC_OP_QUAD_ENTER:
                    begin
                        QUAD_CMD_MODE_O <= 1'b1;
                        CMD_ACCEPT_STB_O <= 1'b1;
                    end
                    `FCC_OP_QUAD_EXIT:
                    begin
                        if (ENH_READ_I)
                        begin
                            ENH_READ_EXIT_O <= 1'b1;
                            CMD_ACCEPT_STB_O <= 1'b1;
                        end
                        else if (QUAD_CMD_MODE_O)
                        begin
                            QUAD_CMD_MODE_O <= 1'b0;
                            CMD_ACCEPT_STB_O <= 1'b1;
                        end
                        else
                        begin
                            CMD_REJECT_STB_O <= 1'b1;
                        end
                    end
                    `FCC_OP_WL_SET:
                    begin
                        WRITE_ENABLE_LATCH_O <= 1'b1;
                        CMD_ACCEPT_STB_O <= 1'b1;
                    end
                    `FCC_OP_WL_CLEAR:
                    begin
                        WRITE_ENABLE_LATCH_O <= 1'b0;
                        CMD_ACCEPT_STB_O <= 1'b1;
                    end
                    `FCC_OP_VOL_WEN:
                    begin
                        VOL_WRITE_ARMED_O <= 1'b1;
                        CMD_ACCEPT_STB_O <= 1'b1;
                    end
                    default:
                    begin
                        if ((QUAD_CMD_MODE_O && is_quad_bad) ||
                            (is_write_op && !WRITE_ENABLE_LATCH_O &&
                            !(op_reg == `FCC_OP_STATUS_WRITE && VOL_WRITE_ARMED_O)))
                        begin
                            CMD_REJECT_STB_O <= 1'b1;
                        end
                        else
                        begin
                            CMD_ACCEPT_STB_O <= 1'b1;
                        end
                    end
                endcase
            end
            if (STATUS_WR_VALID_I && VOL_WRITE_ARMED_O)
            begin
                VOL_STATUS_O <= {STATUS_WR_DATA_I[7:2], 2'b00};
                VOL_STATUS_USE_O <= 1'b1;
                VOL_WRITE_ARMED_O <= 1'b0;
                vol_cnt_reg <= 2'd1;
            end
            else if (!VOL_STATUS_USE_O && !SOFT_RESET_O)
            begin
                VOL_STATUS_O <= {NV_STATUS_I[7:2], 2'b00};
            end
            // latch clears when write completes; done beats a late set
            if (OP_DONE_I)
            begin
                WRITE_ENABLE_LATCH_O <= 1'b0;
            end
        end
    end
endmodule // fcc_ctrl

// ===== fcc_ctrl_asserts.sv
`timescale 1ns/100ps
module fcc_ctrl_asserts
#(
    parameter RECOV_ERASE_CYC = 700,
    parameter RECOV_OTHER_CYC = 25
)
(
    input wire SYS_CLK_I,
    input wire SYS_RST_I,
    input wire OP_BUSY_I,
    input wire OP_DONE_I,
    input wire DEEP_PD_I,
    input wire [7:0] STATUS_WR_DATA_I,
    input wire STATUS_WR_VALID_I,
    input wire QUAD_CMD_MODE_O,
    input wire WRITE_ENABLE_LATCH_O,
    input wire VOL_WRITE_ARMED_O,
    input wire [7:0] VOL_STATUS_O,
    input wire VOL_STATUS_USE_O,
    input wire OP_ABORT_O,
    input wire SOFT_RESET_O,
    input wire RESET_BUSY_O,
    input wire [7:0] CMD_ACCEPT_O,
    input wire CMD_ACCEPT_STB_O
);
    default clocking cb @(posedge SYS_CLK_I); endclocking
    default disable iff (SYS_RST_I);
    wire [5:0] wr_hi = STATUS_WR_DATA_I[7:2];
    reg [15:0] busy_cnt_reg;
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    always @(posedge SYS_CLK_I or posedge SYS_RST_I)
    begin
        if (SYS_RST_I)
            busy_cnt_reg <= 16'h0000;
        else if (RESET_BUSY_O)
            busy_cnt_reg <= busy_cnt_reg + 16'h0001;
        else
            busy_cnt_reg <= 16'h0000;
    end
    sequence s_acc(op);
        CMD_ACCEPT_STB_O && CMD_ACCEPT_O == op;
    endsequence
    sequence s_single_clean;
        !QUAD_CMD_MODE_O && !WRITE_ENABLE_LATCH_O && !VOL_STATUS_USE_O;
    endsequence
    // ----------------------------------------
    // properties
    // ----------------------------------------
    a_reset_to_single: assert property (SOFT_RESET_O |-> ##[0:2] s_single_clean)
        else $error("reset left mode, latch or volatile bits set");
    a_reset_abort_op: assert property (SOFT_RESET_O && OP_BUSY_I |-> ##[0:2] OP_ABORT_O)
        else $error("reset did not abort running op");
    a_powerdown_no_reset: assert property (DEEP_PD_I |-> !SOFT_RESET_O)
        else $error("reset taken in deep power down");
    a_recovery_length: assert property ($fell(RESET_BUSY_O) |->
        busy_cnt_reg >= RECOV_OTHER_CYC && busy_cnt_reg <= RECOV_ERASE_CYC + 1)
        else $error("reset recovery length out of range");
    a_done_clears_latch: assert property (OP_DONE_I |=> !WRITE_ENABLE_LATCH_O)
        else $error("latch not cleared on op completion");
    a_quad_refuse_op: assert property (CMD_ACCEPT_STB_O && QUAD_CMD_MODE_O |->
        !(CMD_ACCEPT_O inside {8'h03, 8'h13, 8'h3B, 8'h3C, 8'hBB, 8'hBC, 8'h6B, 8'h6C, 8'h32,
        8'h34}))
        else $error("single-line opcode accepted in quad mode");
    a_write_needs_latch: assert property (CMD_ACCEPT_STB_O &&
        (CMD_ACCEPT_O inside {8'h02, 8'h12, 8'h32, 8'h34, 8'h20, 8'h21, 8'h52, 8'h5C, 8'hD8,
        8'hDC, 8'hC7, 8'h60}) |-> $past(WRITE_ENABLE_LATCH_O))
        else $error("write op accepted with latch clear");
    a_latch_set_cmd: assert property (s_acc(8'h06) ##0 !OP_DONE_I |-> ##[0:1] WRITE_ENABLE_LATCH_O)
        else $error("latch not set");
    a_latch_clear_cmd: assert property (s_acc(8'h04) |-> ##[0:1] !WRITE_ENABLE_LATCH_O)
        else $error("latch not cleared");
    a_vol_arm_only: assert property (s_acc(8'h50) ##0 !WRITE_ENABLE_LATCH_O
        |-> ##[0:1] (VOL_WRITE_ARMED_O && !WRITE_ENABLE_LATCH_O))
        else $error("volatile enable set latch or did not arm");
    a_vol_load_time: assert property (VOL_WRITE_ARMED_O && STATUS_WR_VALID_I
        |=> VOL_STATUS_USE_O && VOL_STATUS_O[7:2] == $past(wr_hi))
        else $error("volatile status not loaded in time");
endmodule // fcc_ctrl_asserts
bind fcc_ctrl fcc_ctrl_asserts #(.RECOV_ERASE_CYC(RECOV_ERASE_CYC),
    .RECOV_OTHER_CYC(RECOV_OTHER_CYC)) u_asserts (.*);

// ===== fcc_host_model.sv
`timescale 1ns/100ps
module fcc_host_model
(
    input wire clk_i,
    input wire [3:0] dq_i,
    output reg cs_n_o,
    output reg sclk_o,
    output reg [3:0] dq_o
);
    initial
    begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        dq_o = 4'hF;
    end
    // half of a 320 ns serial clock period
    task half;
        begin
            repeat (4) @(negedge clk_i);
        end
    endtask
    task frame(input [7:0] op, input quad, input integer nb, input integer rb,
        output [15:0] rd);
        integer i;
        begin
            rd = 16'h0000;
            @(negedge clk_i);
            cs_n_o = 1'b0;
            for (i = 0; i < nb; i = i + 1)
            begin
                if (quad)
                    dq_o = i[0] ? op[3:0] : op[7:4];
                else
                    dq_o = {3'b111, op[7 - i]};
                half();
                sclk_o = 1'b1;
                half();
                sclk_o = 1'b0;
            end
            for (i = 0; i < rb; i = i + 1)
            begin
                half();
                sclk_o = 1'b1;
                rd = quad ? {rd[11:0], dq_i} : {rd[14:0], dq_i[1]};
                half();
                sclk_o = 1'b0;
            end
            half();
            cs_n_o = 1'b1;
            // released lines must not keep the last value
            dq_o = ~dq_o;
            repeat (8) @(negedge clk_i);
        end
    endtask
endmodule // fcc_host_model

// ===== flash_reset_mode_write_enable_ctrl_test.sv
`timescale 1ns/100ps
`include "fcc_defines.vh"
module flash_reset_mode_write_enable_ctrl_test;
    localparam RE = 12;
    localparam RO = 4;
    reg clk, rst, busy, erase, done, pd, enh, wr_v;
    reg [7:0] nv, wr_d;
    reg [15:0] rd;
    reg [79:0] bad = {8'h03, 8'h13, 8'h3B, 8'h3C, 8'hBB, 8'hBC, 8'h6B, 8'h6C, 8'h32, 8'h34};
    wire cs_n, sclk, quad, enh_exit, latch, armed, vol_use, abort, srst, rbusy, acc_stb, rej_stb;
    wire [3:0] dq, dq_o, dq_oe;
    wire [7:0] vol, acc;
    integer fail_count = 0, check_count = 0, cyc = 0, n_acc = 0, n_rej = 0;
    integer n_rst = 0, n_abort = 0, n_exit = 0, n_busy = 0;
    // an undriven line reads back inverted, so a missing output enable shows up
    fcc_host_model u_host (.clk_i(clk), .dq_i(dq_o ^ ~dq_oe), .cs_n_o(cs_n), .sclk_o(sclk),
        .dq_o(dq));
    fcc_ctrl #(.RECOV_ERASE_CYC(RE), .RECOV_OTHER_CYC(RO)) u_dut (.SYS_CLK_I(clk),
        .SYS_RST_I(rst), .CS_N_I(cs_n), .SCLK_I(sclk), .DQ_I(dq), .NV_STATUS_I(nv),
        .OP_BUSY_I(busy), .OP_IS_ERASE_I(erase), .OP_DONE_I(done), .DEEP_PD_I(pd),
        .ENH_READ_I(enh), .STATUS_WR_DATA_I(wr_d), .STATUS_WR_VALID_I(wr_v), .DQ_O(dq_o),
        .DQ_OE_O(dq_oe), .QUAD_CMD_MODE_O(quad), .ENH_READ_EXIT_O(enh_exit),
        .WRITE_ENABLE_LATCH_O(latch), .VOL_WRITE_ARMED_O(armed), .VOL_STATUS_O(vol),
        .VOL_STATUS_USE_O(vol_use), .OP_ABORT_O(abort), .SOFT_RESET_O(srst),
        .RESET_BUSY_O(rbusy), .CMD_ACCEPT_O(acc), .CMD_ACCEPT_STB_O(acc_stb),
        .CMD_REJECT_STB_O(rej_stb));
    initial
    begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    always @(posedge clk)
    begin
        cyc <= cyc + 1;
        n_acc <= n_acc + (acc_stb === 1'b1);
        n_rej <= n_rej + (rej_stb === 1'b1);
        n_rst <= n_rst + (srst === 1'b1);
        n_abort <= n_abort + (abort === 1'b1);
        n_exit <= n_exit + (enh_exit === 1'b1);
        n_busy <= n_busy + (rbusy === 1'b1);
        if (cyc == 20000)
        begin
            fail_count = fail_count + 1;
            stop_test;
        end
    end
    task stop_test;
        begin
            $display("checks %0d mismatches %0d", check_count, fail_count);
            if (fail_count == 0 && check_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp)
            begin
                $display("unexpected %s: expected %h, seen %h", name, exp, seen);
                fail_count = fail_count + 1;
            end
        end
    endtask
    task cmd(input [7:0] op, input q, input integer nb, input integer ea, input integer er);
        integer a0, r0;
        begin
            a0 = n_acc;
            r0 = n_rej;
            u_host.frame(op, q, nb, 0, rd);
            check("accept", n_acc - a0, ea);
            check("reject", n_rej - r0, er);
            if (ea == 1)
                check("opcode", acc, op);
        end
    endtask
    task settle;
        integer i;
        begin
            i = 0;
            while (rbusy !== 1'b0 && i < 100)
            begin
                @(negedge clk);
                i = i + 1;
            end
            check("settle", rbusy, 1'b0);
        end
    endtask
    task t_latch;
        begin
            cmd(`FCC_OP_WL_SET, 0, 5, 0, 0);
            check("latch", latch, 1'b0);
            busy = 1'b1;
            cmd(`FCC_OP_WL_SET, 0, 8, 1, 0);
            check("latch", latch, 1'b1);
            u_host.frame(`FCC_OP_STATUS_READ, 0, 8, 16, rd);
            check("status_low", rd[9:8], 2'b11);
            check("status", rd[15:8], 8'hAB);
            check("status_repeat", rd[15:8], rd[7:0]);
            check("dq_oe", dq_oe, 4'h0);
            busy = 1'b0;
            cmd(`FCC_OP_PROG, 0, 8, 1, 0);
            @(negedge clk) done = 1'b1;
            @(negedge clk) done = 1'b0;
            @(negedge clk);
            check("latch", latch, 1'b0);
            cmd(`FCC_OP_PROG, 0, 8, 0, 1);
            cmd(`FCC_OP_WL_SET, 0, 8, 1, 0);
            cmd(`FCC_OP_WL_CLEAR, 0, 8, 1, 0);
            check("latch", latch, 1'b0);
        end
    endtask
    task t_reset;
        integer b0, be, k0;
        begin
            // a running erase, so recovery takes the erase length
            busy = 1'b1;
            erase = 1'b1;
            k0 = n_abort;
            cmd(`FCC_OP_RESET_ARM, 0, 8, 1, 0);
            b0 = n_busy;
            cmd(`FCC_OP_RESET, 0, 8, 1, 0);
            settle;
            check("abort", n_abort - k0, 1);
            be = n_busy - b0;
            busy = 1'b0;
            erase = 1'b0;
            cmd(`FCC_OP_RESET_ARM, 0, 8, 1, 0);
            b0 = n_busy;
            cmd(`FCC_OP_RESET, 0, 8, 1, 0);
            settle;
            check("erase_longer", be > n_busy - b0, 1);
            cmd(`FCC_OP_RESET_ARM, 0, 8, 1, 0);
            cmd(`FCC_OP_WL_SET, 0, 8, 1, 0);
            cmd(`FCC_OP_RESET, 0, 8, 0, 1);
            check("latch", latch, 1'b1);
            k0 = n_rst;
            pd = 1'b1;
            u_host.frame(`FCC_OP_RESET_ARM, 0, 8, 0, rd);
            u_host.frame(`FCC_OP_RESET, 0, 8, 0, rd);
            pd = 1'b0;
            check("pd_reset", n_rst - k0, 0);
            check("latch", latch, 1'b1);
        end
    endtask
    task t_quad;
        integer i, e0;
        begin
            cmd(`FCC_OP_QUAD_EXIT, 0, 8, 0, 1);
            cmd(`FCC_OP_QUAD_ENTER, 0, 8, 1, 0);
            check("quad", quad, 1'b1);
            cmd(`FCC_OP_WL_CLEAR, 1, 2, 1, 0);
            u_host.frame(`FCC_OP_STATUS_READ, 1, 2, 2, rd);
            check("status_quad", rd[7:0], 8'hA8);
            for (i = 0; i < 10; i = i + 1)
                cmd(bad[i * 8 +: 8], 1, 2, 0, 1);
            enh = 1'b1;
            e0 = n_exit;
            cmd(`FCC_OP_QUAD_EXIT, 1, 2, 1, 0);
            enh = 1'b0;
            check("enh_exit", n_exit - e0, 1);
            check("quad", quad, 1'b1);
            cmd(`FCC_OP_QUAD_EXIT, 1, 2, 1, 0);
            check("quad", quad, 1'b0);
            cmd(`FCC_OP_QUAD_ENTER, 0, 8, 1, 0);
            cmd(`FCC_OP_WL_SET, 1, 2, 1, 0);
            cmd(`FCC_OP_RESET_ARM, 1, 2, 1, 0);
            cmd(`FCC_OP_RESET, 1, 2, 1, 0);
            settle;
            check("quad", quad, 1'b0);
            check("latch", latch, 1'b0);
            cmd(`FCC_OP_RESET_ARM, 1, 2, 0, 0);
            cmd(`FCC_OP_RESET, 1, 2, 0, 0);
            cmd(`FCC_OP_RESET_ARM, 0, 8, 1, 0);
            cmd(`FCC_OP_RESET, 0, 8, 1, 0);
            settle;
        end
    endtask
    task t_vol;
        begin
            cmd(`FCC_OP_VOL_WEN, 0, 8, 1, 0);
            check("latch", latch, 1'b0);
            check("armed", armed, 1'b1);
            @(negedge clk);
            wr_d = 8'hB4;
            wr_v = 1'b1;
            @(negedge clk) wr_v = 1'b0;
            check("vol", vol[7:2], 6'h2D);
            check("vol_use", vol_use, 1'b1);
            cmd(`FCC_OP_RESET_ARM, 0, 8, 1, 0);
            cmd(`FCC_OP_RESET, 0, 8, 1, 0);
            settle;
            check("vol_use", vol_use, 1'b0);
            check("vol", vol[7:2], 6'h2A);
        end
    endtask
    initial
    begin
        rst = 1'b1;
        {busy, erase, done, pd, enh, wr_v} = 6'b00_0000;
        nv = 8'hA8;
        wr_d = 8'h00;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (4) @(negedge clk);
        t_latch;
        t_reset;
        t_quad;
        t_vol;
        stop_test;
    end
endmodule // flash_reset_mode_write_enable_ctrl_test
